// ===== audio_defines.svh
`ifndef AUDIO_DEFINES_SVH
`define AUDIO_DEFINES_SVH
// register indices on the host register port
`define A_EFF_SEL 4'h0
`define A_EFF_VOL 4'h1
`define A_EFF_TRIG 4'h2
`define A_PB_START 4'h3
`define A_PB_LEN 4'h4
`define A_PB_RATE 4'h5
`define A_PB_FMT 4'h6
`define A_PB_LOOP 4'h7
`define A_PB_TRIG 4'h8
`define A_PB_VOL 4'h9
`define A_PB_PTR 4'ha
// widths and reset values
`define RAM_AW 20
`define RST_VOL 8'hff
`define RST_DUTY 8'h80
// effect select fields and limits, adaptive delta step index limit
`define SEL_CODE 7:0
`define SEL_NOTE 15:8
`define ONESHOT_MIN 8'h40
`define NOTE_MIDDLE_C 8'h3c
`define NOTE_MAX 8'h7f
`define ADPCM_IDX_MAX 9'h058
// timing
`define CLK_HZ 28'h5f5e100
`define CLK_MHZ 100
`define SHOT_MS 100
`define SHOT_CYC (`SHOT_MS * 1000 * `CLK_MHZ)
`endif

// ===== audio_engine.sv
`timescale 1ns/1ps
`include "audio_defines.svh"
module audio_engine #(
	parameter int unsigned SHOT_CYCLES = `SHOT_CYC
) (
	// clock, reset, enable
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	// host register port
	input wire audio_pkg::reg_req_t i_reg,
	output logic [31:0] o_reg_rdata,
	// sample ram, data returns the cycle after the request
	output audio_pkg::ram_req_t o_ram,
	input wire logic [7:0] i_ram_data,
	// audio pin
	output logic o_audio_pwm
);
	import audio_pkg::*;

	localparam logic signed [7:0] SINE [16] = '{8'sh00, 8'sh31, 8'sh5a, 8'sh75,
		8'sh7f, 8'sh75, 8'sh5a, 8'sh31, 8'sh00, 8'shcf, 8'sha6, 8'sh8b,
		8'sh81, 8'sh8b, 8'sha6, 8'shcf};
	// phase steps for the lowest octave; higher octaves shift left
	localparam logic [9:0] BASE_INC [12] = '{10'h15f, 10'h174, 10'h18a, 10'h1a2,
		10'h1ba, 10'h1d5, 10'h1f1, 10'h20e, 10'h22d, 10'h24e, 10'h271, 10'h297};
	localparam logic [15:0] STEP [89] = '{16'h0007, 16'h0008, 16'h0009, 16'h000a,
		16'h000b, 16'h000c, 16'h000d, 16'h000e, 16'h0010, 16'h0011, 16'h0013,
		16'h0015, 16'h0017, 16'h0019, 16'h001c, 16'h001f, 16'h0022, 16'h0025,
		16'h0029, 16'h002d, 16'h0032, 16'h0037, 16'h003c, 16'h0042, 16'h0049,
		16'h0050, 16'h0058, 16'h0061, 16'h006b, 16'h0076, 16'h0082, 16'h008f,
		16'h009d, 16'h00ad, 16'h00be, 16'h00d1, 16'h00e6, 16'h00fd, 16'h0117,
		16'h0133, 16'h0151, 16'h0173, 16'h0198, 16'h01c1, 16'h01ee, 16'h0220,
		16'h0256, 16'h0292, 16'h02d4, 16'h031c, 16'h036c, 16'h03c3, 16'h0424,
		16'h048e, 16'h0502, 16'h0583, 16'h0610, 16'h06ab, 16'h0756, 16'h0812,
		16'h08e0, 16'h09c3, 16'h0abd, 16'h0bd0, 16'h0cff, 16'h0e4c, 16'h0fba,
		16'h114c, 16'h1307, 16'h14ee, 16'h1706, 16'h1954, 16'h1bdc, 16'h1ea5,
		16'h21b6, 16'h2515, 16'h28ca, 16'h2cdf, 16'h315b, 16'h364b, 16'h3bb9,
		16'h41b2, 16'h4844, 16'h4f7e, 16'h5771, 16'h602f, 16'h69ce, 16'h7462,
		16'h7fff};

	logic [15:0] eff_sel_ff, nxt_eff_sel;
	logic [7:0] eff_vol_ff, nxt_eff_vol, pb_vol_ff, nxt_pb_vol;
	logic eff_on_ff, nxt_eff_on;
	logic [31:0] phase_ff, nxt_phase, dur_ff, nxt_dur;
	logic [`RAM_AW-1:0] start_ff, nxt_start, len_ff, nxt_len;
	logic [`RAM_AW-1:0] ptr_ff, nxt_ptr, cnt_ff, nxt_cnt;
	logic [15:0] rate_ff, nxt_rate;
	logic [27:0] acc_ff, nxt_acc, acc_sum;
	coding_t fmt_ff, nxt_fmt;
	logic loop_ff, nxt_loop;
	pb_state_t pb_ff, nxt_pb;
	logic [7:0] byte_ff, nxt_byte;
	logic nib_ff, nxt_nib;
	logic signed [15:0] smp_ff, nxt_smp, pred_ff, nxt_pred;
	logic [6:0] idx_ff, nxt_idx;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [7:0] pwm_cnt_ff, nxt_pwm_cnt, duty_ff, nxt_duty;
	logic pwm_ff, nxt_pwm;

	// pitch and wave
	logic oneshot;
	logic [7:0] raw_note, note, tri_u;
	logic [3:0] oct, semi;
	logic [31:0] inc;
	logic signed [7:0] wave;
	assign oneshot = eff_sel_ff[`SEL_CODE] >= `ONESHOT_MIN;
	assign raw_note = eff_sel_ff[`SEL_NOTE];
	assign note = (oneshot || raw_note == 8'h00) ? `NOTE_MIDDLE_C :
		((raw_note > `NOTE_MAX) ? `NOTE_MAX : raw_note);
	assign oct = 4'(note / 8'h0c);
	assign semi = 4'(note % 8'h0c);
	assign inc = 32'(BASE_INC[semi]) << oct;
	assign tri_u = phase_ff[31] ? ~phase_ff[30:23] : phase_ff[30:23];
	always_comb begin
		case (eff_sel_ff[1:0])
		2'h0: wave = SINE[phase_ff[31:28]];
		2'h1: wave = phase_ff[31] ? 8'sh81 : 8'sh7f;
		2'h2: wave = {~phase_ff[31], phase_ff[30:24]};
		default: wave = {~tri_u[7], tri_u[6:0]};
		endcase
	end

	// sample decoders
	logic [3:0] nib;
	logic [15:0] step, mu_t, mu;
	logic [17:0] diff, pr;
	logic [8:0] ix;
	logic [7:0] mu_n;
	logic signed [15:0] pr_sat, dec;
	logic [6:0] ix_sat;
	assign nib = nib_ff ? byte_ff[7:4] : byte_ff[3:0];
	assign step = STEP[idx_ff];
	assign diff = 18'(step >> 3) + (nib[2] ? 18'(step) : 18'h0)
		+ (nib[1] ? 18'(step >> 1) : 18'h0) + (nib[0] ? 18'(step >> 2) : 18'h0);
	assign pr = {{2{pred_ff[15]}}, pred_ff} + (nib[3] ? -diff : diff);
	assign pr_sat = ($signed(pr) > 18'sh07fff) ? 16'sh7fff :
		(($signed(pr) < -18'sh08000) ? 16'sh8000 : pr[15:0]);
	assign ix = {2'h0, idx_ff} + (nib[2] ? 9'({nib[1:0], 1'b0}) + 9'h002 : 9'h1ff);
	assign ix_sat = ix[8] ? 7'h00 : ((ix > `ADPCM_IDX_MAX) ? 7'(`ADPCM_IDX_MAX) : ix[6:0]);
	assign mu_n = ~byte_ff;
	assign mu_t = 16'({mu_n[3:0], 3'h0} + 8'h84) << mu_n[6:4];
	assign mu = mu_n[7] ? 16'h0084 - mu_t : mu_t - 16'h0084;
	always_comb begin
		case (fmt_ff)
		coding_mulaw: dec = mu;
		coding_adaptive_delta: dec = pr_sat;
		default: dec = {byte_ff, 8'h00};
		endcase
	end

	// sample clock: fractional accumulator avoids a divider
	logic tick;
	assign acc_sum = acc_ff + 28'(rate_ff);
	assign tick = acc_sum >= `CLK_HZ;

	logic eff_trig_wr, pb_trig_wr;
	assign eff_trig_wr = i_reg.wr && i_reg.addr == `A_EFF_TRIG && i_reg.wdata[0];
	assign pb_trig_wr = i_reg.wr && i_reg.addr == `A_PB_TRIG;
	assign o_ram = '{rd: (pb_ff == PB_REQ), addr: ptr_ff};

	always_comb begin
		nxt_eff_sel = eff_sel_ff;
		nxt_eff_vol = eff_vol_ff;
		nxt_pb_vol = pb_vol_ff;
		nxt_eff_on = eff_on_ff;
		nxt_phase = phase_ff;
		nxt_dur = dur_ff;
		nxt_start = start_ff;
		nxt_len = len_ff;
		nxt_ptr = ptr_ff;
		nxt_cnt = cnt_ff;
		nxt_rate = rate_ff;
		nxt_acc = acc_ff;
		nxt_fmt = fmt_ff;
		nxt_loop = loop_ff;
		nxt_pb = pb_ff;
		nxt_byte = byte_ff;
		nxt_nib = nib_ff;
		nxt_smp = smp_ff;
		nxt_pred = pred_ff;
		nxt_idx = idx_ff;
		if (i_reg.wr) begin
			case (i_reg.addr)
			`A_EFF_SEL: nxt_eff_sel = i_reg.wdata[15:0];
			`A_EFF_VOL: nxt_eff_vol = i_reg.wdata[7:0];
			`A_PB_START: nxt_start = i_reg.wdata[`RAM_AW-1:0];
			`A_PB_LEN: nxt_len = i_reg.wdata[`RAM_AW-1:0];
			`A_PB_RATE: nxt_rate = i_reg.wdata[15:0];
			`A_PB_FMT: nxt_fmt = coding_t'(i_reg.wdata[1:0]);
			`A_PB_LOOP: nxt_loop = i_reg.wdata[0];
			`A_PB_VOL: nxt_pb_vol = i_reg.wdata[7:0];
			default: ;
			endcase
		end
		// codes below the one-shot range run until replaced
		if (eff_on_ff) begin
			nxt_phase = phase_ff + inc;
			if (oneshot) begin
				if (dur_ff == 32'h0)
					nxt_eff_on = 1'b0;
				else
					nxt_dur = dur_ff - 32'h1;
			end
		end
		// the select value latched before the trigger is the one played
		if (eff_trig_wr) begin
			nxt_eff_on = eff_sel_ff[`SEL_CODE] != 8'h00;
			nxt_phase = 32'h0;
			nxt_dur = 32'(SHOT_CYCLES - 1);
		end
		nxt_acc = tick ? acc_sum - `CLK_HZ : acc_sum;
		case (pb_ff)
		PB_REQ: nxt_pb = PB_DATA;
		PB_DATA: begin
			nxt_byte = i_ram_data;
			nxt_nib = 1'b0;
			nxt_pb = PB_PLAY;
		end
		PB_PLAY: begin
			if (tick) begin
				nxt_smp = dec;
				if (fmt_ff == coding_adaptive_delta) begin
					nxt_pred = pr_sat;
					nxt_idx = ix_sat;
				end
				if (fmt_ff == coding_adaptive_delta && !nib_ff) begin
					nxt_nib = 1'b1;
				end else if (cnt_ff == len_ff - 1'b1) begin
					if (loop_ff) begin
						nxt_ptr = start_ff;
						nxt_cnt = '0;
						nxt_pb = PB_REQ;
					end else begin
						nxt_pb = PB_IDLE;
					end
				end else begin
					nxt_ptr = ptr_ff + 1'b1;
					nxt_cnt = cnt_ff + 1'b1;
					nxt_pb = PB_REQ;
				end
			end
		end
		default: nxt_smp = 16'sh0000;
		endcase
		if (pb_trig_wr) begin
			nxt_ptr = start_ff;
			nxt_cnt = '0;
			nxt_acc = 28'h0;
			nxt_pred = 16'sh0000;
			nxt_idx = 7'h00;
			nxt_pb = (len_ff == '0) ? PB_IDLE : PB_REQ;
		end
		case (i_reg.addr)
		`A_EFF_SEL: nxt_rdata = {16'h0, eff_sel_ff};
		`A_EFF_VOL: nxt_rdata = {24'h0, eff_vol_ff};
		`A_EFF_TRIG: nxt_rdata = {31'h0, eff_on_ff};
		`A_PB_START: nxt_rdata = 32'(start_ff);
		`A_PB_LEN: nxt_rdata = 32'(len_ff);
		`A_PB_RATE: nxt_rdata = {16'h0, rate_ff};
		`A_PB_FMT: nxt_rdata = {30'h0, fmt_ff};
		`A_PB_LOOP: nxt_rdata = {31'h0, loop_ff};
		`A_PB_TRIG: nxt_rdata = {31'h0, pb_ff != PB_IDLE};
		`A_PB_VOL: nxt_rdata = {24'h0, pb_vol_ff};
		`A_PB_PTR: nxt_rdata = 32'(ptr_ff);
		default: nxt_rdata = 32'h0;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			eff_sel_ff <= 16'h0;
			eff_vol_ff <= `RST_VOL;
			pb_vol_ff <= `RST_VOL;
			eff_on_ff <= 1'b0;
			phase_ff <= 32'h0;
			dur_ff <= 32'h0;
			start_ff <= '0;
			len_ff <= '0;
			ptr_ff <= '0;
			cnt_ff <= '0;
			rate_ff <= 16'h0;
			acc_ff <= 28'h0;
			fmt_ff <= coding_linear;
			loop_ff <= 1'b0;
			pb_ff <= PB_IDLE;
			byte_ff <= 8'h0;
			nib_ff <= 1'b0;
			smp_ff <= 16'sh0000;
			pred_ff <= 16'sh0000;
			idx_ff <= 7'h00;
			rdata_ff <= 32'h0;
		end else if (i_clk_en) begin
			eff_sel_ff <= nxt_eff_sel;
			eff_vol_ff <= nxt_eff_vol;
			pb_vol_ff <= nxt_pb_vol;
			eff_on_ff <= nxt_eff_on;
			phase_ff <= nxt_phase;
			dur_ff <= nxt_dur;
			start_ff <= nxt_start;
			len_ff <= nxt_len;
			ptr_ff <= nxt_ptr;
			cnt_ff <= nxt_cnt;
			rate_ff <= nxt_rate;
			acc_ff <= nxt_acc;
			fmt_ff <= nxt_fmt;
			loop_ff <= nxt_loop;
			pb_ff <= nxt_pb;
			byte_ff <= nxt_byte;
			nib_ff <= nxt_nib;
			smp_ff <= nxt_smp;
			pred_ff <= nxt_pred;
			idx_ff <= nxt_idx;
			rdata_ff <= nxt_rdata;
		end
	end
	assign o_reg_rdata = rdata_ff;

	// mixer and pwm
	logic signed [7:0] syn;
	logic signed [16:0] s_eff;
	logic signed [24:0] s_pb;
	logic signed [17:0] mix;
	logic signed [15:0] sat;
	assign syn = eff_on_ff ? wave : 8'sh00;
	assign s_eff = syn * $signed({1'b0, eff_vol_ff});
	assign s_pb = smp_ff * $signed({1'b0, pb_vol_ff});
	assign mix = 18'(s_eff) + 18'(s_pb >>> 8);
	assign sat = (mix > 18'sh07fff) ? 16'sh7fff : ((mix < -18'sh08000) ? 16'sh8000 : mix[15:0]);
	always_comb begin
		nxt_pwm_cnt = pwm_cnt_ff + 8'h01;
		// duty only changes at a period boundary to avoid runt pulses
		nxt_duty = (pwm_cnt_ff == 8'hff) ? {~sat[15], sat[14:8]} : duty_ff;
		nxt_pwm = pwm_cnt_ff < duty_ff;
	end
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pwm_cnt_ff <= 8'h00;
			duty_ff <= `RST_DUTY;
			pwm_ff <= 1'b0;
		end else if (i_clk_en) begin
			pwm_cnt_ff <= nxt_pwm_cnt;
			duty_ff <= nxt_duty;
			pwm_ff <= nxt_pwm;
		end
	end
	assign o_audio_pwm = pwm_ff;
endmodule : audio_engine

// ===== audio_engine_assertions.sv
`timescale 1ns/1ps
`include "audio_defines.svh"
module audio_engine_assertions #(
	parameter int unsigned SHOT_CYCLES = 50
) (
	// clock and control
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	// register port
	input wire audio_pkg::reg_req_t i_reg,
	input wire logic [31:0] o_reg_rdata,
	// ram and pin
	input wire audio_pkg::ram_req_t o_ram,
	input wire logic [7:0] i_ram_data,
	input wire logic o_audio_pwm
);
	import audio_pkg::*;
	logic [15:0] sel_ff, nxt_sel;
	logic [19:0] start_ff, nxt_start, len_ff, nxt_len;
	logic wr_ok;
	// shadow copies let the checker know what the trigger will act on
	always_comb begin
		wr_ok = i_reg.wr && i_clk_en;
		nxt_sel = sel_ff;
		nxt_start = start_ff;
		nxt_len = len_ff;
		if (wr_ok && i_reg.addr == `A_EFF_SEL) nxt_sel = i_reg.wdata[15:0];
		if (wr_ok && i_reg.addr == `A_PB_START) nxt_start = i_reg.wdata[19:0];
		if (wr_ok && i_reg.addr == `A_PB_LEN) nxt_len = i_reg.wdata[19:0];
	end
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sel_ff <= 16'h0;
			start_ff <= 20'h0;
			len_ff <= 20'h0;
		end else begin
			sel_ff <= nxt_sel;
			start_ff <= nxt_start;
			len_ff <= nxt_len;
		end
	end
	// a frozen edge aborts the check rather than judging stale state
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n || !i_clk_en);
	property p_rst_clear;
		$rose(i_rst_n) |-> (o_reg_rdata == 32'h0 && !o_audio_pwm && o_ram.addr == 20'h0);
	endproperty
	a_rst_clear: assert property (p_rst_clear) else $error("outputs not clear after reset");
	property p_rd_spacing;
		o_ram.rd |=> !o_ram.rd [*2];
	endproperty
	a_rd_spacing: assert property (p_rd_spacing) else $error("ram reads too close");
	property p_sel_read;
		i_reg.addr == `A_EFF_SEL |=> o_reg_rdata == {16'h0, $past(sel_ff)};
	endproperty
	a_sel_read: assert property (p_sel_read) else $error("effect select readback wrong");
	property p_ptr_read;
		i_reg.addr == `A_PB_PTR |=> o_reg_rdata == {12'h0, $past(o_ram.addr)};
	endproperty
	a_ptr_read: assert property (p_ptr_read) else $error("fetch pointer readback wrong");
	property p_unmapped;
		i_reg.addr > `A_PB_PTR |=> o_reg_rdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped index read nonzero");
	property p_eff_on;
		(wr_ok && i_reg.addr == `A_EFF_TRIG && i_reg.wdata[0] && sel_ff[7:0] != 8'h0)
			##1 (i_reg.addr == `A_EFF_TRIG) |=> o_reg_rdata[0];
	endproperty
	a_eff_on: assert property (p_eff_on) else $error("effect not sounding");
	property p_eff_silence;
		(wr_ok && i_reg.addr == `A_EFF_TRIG && i_reg.wdata[0] && sel_ff[7:0] == 8'h0)
			##1 (i_reg.addr == `A_EFF_TRIG) |=> !o_reg_rdata[0];
	endproperty
	a_eff_silence: assert property (p_eff_silence) else $error("silence did not stop");
	property p_pb_start;
		(wr_ok && i_reg.addr == `A_PB_TRIG && len_ff != 20'h0)
			|=> (o_ram.rd && o_ram.addr == start_ff);
	endproperty
	a_pb_start: assert property (p_pb_start) else $error("playback fetch wrong");
	property p_pb_on;
		(wr_ok && i_reg.addr == `A_PB_TRIG && len_ff != 20'h0)
			##1 (i_reg.addr == `A_PB_TRIG) |=> o_reg_rdata[0];
	endproperty
	a_pb_on: assert property (p_pb_on) else $error("playback not reported");
	property p_pb_len0;
		(wr_ok && i_reg.addr == `A_PB_TRIG && len_ff == 20'h0) |=> !o_ram.rd [*3];
	endproperty
	a_pb_len0: assert property (p_pb_len0) else $error("empty playback fetched");
endmodule : audio_engine_assertions
bind audio_engine audio_engine_assertions #(.SHOT_CYCLES(SHOT_CYCLES)) u_chk (
	.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en), .i_reg(i_reg),
	.o_reg_rdata(o_reg_rdata), .o_ram(o_ram), .i_ram_data(i_ram_data),
	.o_audio_pwm(o_audio_pwm));

// ===== audio_pkg.sv
`include "audio_defines.svh"
package audio_pkg;
	typedef enum logic [1:0] {coding_linear, coding_mulaw, coding_adaptive_delta} coding_t;
	typedef enum logic [1:0] {PB_IDLE, PB_REQ, PB_DATA, PB_PLAY} pb_state_t;
	typedef struct packed {
		logic wr;
		logic [3:0] addr;
		logic [31:0] wdata;
	} reg_req_t;
	typedef struct packed {
		logic rd;
		logic [`RAM_AW-1:0] addr;
	} ram_req_t;
endpackage : audio_pkg

// ===== audio_ram_model.sv
`timescale 1ns/1ps
module audio_ram_model (
	// clock and request
	input wire logic i_core_clk,
	input wire audio_pkg::ram_req_t i_ram,
	// returned byte
	output logic [7:0] o_data
);
	import audio_pkg::*;
	// between reads the bus shows the inverse, so a late latch gets garbage
	always_ff @(posedge i_core_clk) begin
		if (i_ram.rd) begin
			o_data <= i_ram.addr[7:0] ^ 8'h5a;
		end else begin
			o_data <= ~o_data;
		end
	end
endmodule : audio_ram_model

// ===== tb_audio_engine.sv
`timescale 1ns/1ps
`include "audio_defines.svh"
module tb_audio_engine;
	import audio_pkg::*;
	localparam int unsigned SHOT = 50;
	logic i_core_clk, i_rst_n, i_clk_en, o_audio_pwm;
	reg_req_t i_reg;
	ram_req_t o_ram;
	logic [31:0] o_reg_rdata, lfsr, rv;
	logic [7:0] i_ram_data;
	logic [19:0] pb_start, pb_len;
	int fail_count, num_checks, rd_seen, n, lo;
	audio_engine #(.SHOT_CYCLES(SHOT)) dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en), .i_reg(i_reg), .o_reg_rdata(o_reg_rdata), .o_ram(o_ram),
		.i_ram_data(i_ram_data), .o_audio_pwm(o_audio_pwm));
	audio_ram_model ram (.i_core_clk(i_core_clk), .i_ram(o_ram), .o_data(i_ram_data));
	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	function automatic logic [31:0] reg_mask(input logic [3:0] a);
		case (a)
			`A_EFF_SEL, `A_PB_RATE: return 32'hffff;
			`A_EFF_VOL, `A_PB_VOL: return 32'hff;
			`A_PB_START, `A_PB_LEN: return 32'hfffff;
			`A_PB_FMT: return 32'h3;
			`A_PB_LOOP: return 32'h1;
			default: return 32'h0;
		endcase
	endfunction : reg_mask
	// offset binary: full negative gives 0, silence gives the midpoint
	function automatic int duty_of(input int s);
		return (s + 32768) / 256;
	endfunction : duty_of
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : close_out
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		i_reg <= '{1'b1, a, d};
		@(posedge i_core_clk);
		i_reg.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge i_core_clk);
		i_reg.addr <= a;
		@(posedge i_core_clk);
		#1 v = o_reg_rdata;
	endtask : rd
	task automatic poll(input logic [3:0] a, input logic want, input int lim, output int t);
		logic [31:0] v;
		t = 0;
		rd(a, v);
		while (v[0] !== want) begin
			@(posedge i_core_clk);
			#1 v = o_reg_rdata;
			t++;
			if (t > lim) begin
				fail_count++;
				$display("timeout at %0t", $time);
				close_out();
			end
		end
	endtask : poll
	task automatic pwm_count(output int c);
		c = 0;
		repeat (512) begin
			@(posedge i_core_clk);
			#1 if (o_audio_pwm === 1'b1) c++;
		end
	endtask : pwm_count
	always @(posedge i_core_clk) begin
		if (i_rst_n && i_clk_en && o_ram.rd && pb_len != 20'h0) begin
			check(32'(o_ram.addr), 32'(pb_start + 20'(rd_seen % pb_len)));
			rd_seen++;
		end
	end
	initial begin
		fail_count = 0;
		num_checks = 0;
		rd_seen = 0;
		lfsr = 32'h00010456;
		pb_start = 20'h0;
		pb_len = 20'h0;
		i_rst_n = 1'b0;
		i_clk_en = 1'b1;
		i_reg = '0;
		repeat (12) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		for (int a = 0; a < 16; a++) begin
			rd(4'(a), rv);
			check(rv, (a == 1 || a == 9) ? 32'hff : 32'h0);
		end
		repeat (300) @(posedge i_core_clk);
		pwm_count(n);
		check(n, 32'h100);
		$display("test reset done");
		repeat (40) begin
			lfsr = lfsr_next(lfsr);
			if (!(lfsr[3:0] inside {`A_EFF_TRIG, `A_PB_TRIG, `A_PB_PTR})) begin
				wr(lfsr[3:0], lfsr_next(lfsr));
				rd(lfsr[3:0], rv);
				check(rv, lfsr_next(lfsr) & reg_mask(lfsr[3:0]));
			end
		end
		$display("test registers done");
		wr(`A_EFF_VOL, 32'h0);
		wr(`A_PB_VOL, 32'h0);
		wr(`A_EFF_SEL, {16'h0, lfsr[15:8], 8'h41});
		wr(`A_EFF_TRIG, 32'h1);
		poll(`A_EFF_TRIG, 1'b0, SHOT + 10, n);
		check(32'(n >= SHOT - 3), 32'h1);
		wr(`A_EFF_SEL, {16'h0, 1'b0, lfsr[22:16], 8'h05});
		wr(`A_EFF_TRIG, 32'h1);
		repeat (3 * SHOT) @(posedge i_core_clk);
		rd(`A_EFF_TRIG, rv);
		check(rv, 32'h1);
		pwm_count(n);
		check(n, 32'h100);
		wr(`A_EFF_SEL, 32'h00000005);
		wr(`A_EFF_TRIG, 32'h1);
		wr(`A_EFF_VOL, 32'hff);
		// middle c is slow enough that the first half cycle outlasts the count
		repeat (300) @(posedge i_core_clk);
		pwm_count(n);
		check(n, 32'(2 * duty_of(127 * 255)));
		wr(`A_EFF_SEL, 32'h0);
		wr(`A_EFF_TRIG, 32'h1);
		rd(`A_EFF_TRIG, rv);
		check(rv, 32'h0);
		$display("test effects done");
		pb_start = 20'(lfsr[11:0]);
		pb_len = 20'h4;
		wr(`A_PB_START, 32'(pb_start));
		wr(`A_PB_LEN, 32'(pb_len));
		// 2000 cycles a sample keeps the run short but clearly timed
		wr(`A_PB_RATE, 32'h0000c350);
		// the random register pass may have left looping on
		wr(`A_PB_LOOP, 32'h0);
		for (int f = 0; f < 3; f++) begin
			wr(`A_PB_FMT, 32'(f));
			rd_seen = 0;
			wr(`A_PB_TRIG, {lfsr[31:1], 1'b0});
			poll(`A_PB_TRIG, 1'b0, 40000, n);
			check(rd_seen, 4);
			lo = (f == 2 ? 8 : 4) * 2000 - 2000;
			check(32'(n > lo && n < lo + 4500), 32'h1);
			$display("test playback format %0d done", f);
		end
		wr(`A_PB_LOOP, 32'h1);
		rd_seen = 0;
		wr(`A_PB_TRIG, 32'h0);
		for (n = 0; rd_seen < 9 && n < 36000; n++) @(posedge i_core_clk);
		check(32'(rd_seen >= 9), 32'h1);
		rd(`A_PB_TRIG, rv);
		check(rv, 32'h1);
		rd(`A_PB_PTR, rv);
		check(32'(rv - 32'(pb_start) < 32'h4), 32'h1);
		repeat (40) begin
			lfsr = lfsr_next(lfsr);
			@(posedge i_core_clk);
			i_clk_en <= lfsr[0];
		end
		@(posedge i_core_clk);
		i_clk_en <= 1'b1;
		pb_len = 20'h0;
		wr(`A_PB_LEN, 32'h0);
		wr(`A_PB_TRIG, 32'h1);
		rd(`A_PB_TRIG, rv);
		check(rv, 32'h0);
		$display("test looping done");
		@(posedge i_core_clk);
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		rd(`A_EFF_VOL, rv);
		check(rv, 32'hff);
		$display("test second reset done");
		close_out();
	end
endmodule : tb_audio_engine
